/* rtl/esr_pkg.sv */
package esr_pkg;
    // Event status bit positions, shared by the event register and mask
    localparam int ESR_W = 8;
    localparam int BIT_PON = 7;
    localparam int BIT_URQ = 6;
    localparam int BIT_CME = 5;
    localparam int BIT_EXE = 4;
    localparam int BIT_DDE = 3;
    localparam int BIT_QYE = 2;
    localparam int BIT_OPC = 1;
    localparam int BIT_RQC = 0;
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Error queue
    localparam int ERR_W = 8;
    localparam int ERRQ_DEPTH = 4;
    localparam int ERRQ_PW = 2;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_OUTBUF_OVF = 8'h7A;
    // Command codes on the command port
    typedef enum logic [2:0] {
        ESR_CMD_NOP = 3'h0,
        ESR_CMD_CLS = 3'h1,
        ESR_CMD_ESE = 3'h2,
        ESR_CMD_ESEQ = 3'h3,
        ESR_CMD_ESRQ = 3'h4,
        ESR_CMD_FAULTQ = 3'h5,
        ESR_CMD_OPC = 3'h6,
        ESR_CMD_OPCQ = 3'h7
    } esr_cmd_t;
endpackage : esr_pkg

/* rtl/esr_err_queue.sv */
`timescale 1ns/10ps
module esr_err_queue
    import esr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic push,
    input wire logic [ERR_W-1:0] pushCode,
    input wire logic flush,
    output logic [ERR_W-1:0] latest,
    output logic overflow
);
    typedef struct packed {
        logic [ERRQ_DEPTH-1:0][ERR_W-1:0] mem;
        logic [ERRQ_PW:0] count;
    } esr_eq_t;

    esr_eq_t s_q;
    esr_eq_t s_d;

    // Newest at slot 0; oldest falls off when full, flagged as overflow
    always_comb begin
        s_d = s_q;
        overflow = 1'b0;
        if (flush) begin
            s_d.count = '0;
        end
        if (push) begin
            for (int i = ERRQ_DEPTH-1; i > 0; i--) begin
                s_d.mem[i] = s_d.mem[i-1];
            end
            s_d.mem[0] = pushCode;
            if (s_d.count == (ERRQ_PW+1)'(ERRQ_DEPTH)) begin
                overflow = 1'b1;
            end else begin
                s_d.count = s_d.count + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign latest = (s_q.count == '0) ? ERR_NONE : s_q.mem[0];
endmodule : esr_err_queue

/* rtl/esr_status_regs.sv */
`timescale 1ns/10ps
// Behaviour notes for the next owner:
// Commands are taken on any enabled edge with cmdValid high; no backpressure.
// Queries except OPCQ answer one enabled edge later with a one-cycle rspValid pulse.
// rspData holds the last answer until the next query replaces it.
// Event inputs are sampled every enabled cycle, as pulses or as levels.
// A level input keeps its bit set, so a read-and-clear returns it again.
// An event in the same cycle as a clear survives the clear, except opDone, which a clear-status cancels.
// The error queue keeps the newest codes; the oldest one drops when full.
// The error query peeks at the newest code and does not pop it.
// Operation complete fires only while a command or query is pending.
// Clear-status in the same cycle as completion cancels the completion.
// ce low freezes everything, so a response pulse stretches with it.
// Power-on bit is set by reset so the host sees the restart once.
module esr_status_regs
    import esr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic [7:0] cmdParam,
    input wire logic cmdFromSerial,
    output logic cmdReady,
    output logic rspValid,
    output logic [7:0] rspData,
    input wire logic evtUserReq,
    input wire logic evtCmdErr,
    input wire logic evtExecErr,
    input wire logic evtDevErr,
    input wire logic evtQueryErr,
    input wire logic evtReqCtrl,
    input wire logic opDone,
    input wire logic errPush,
    input wire logic [7:0] errCode,
    input wire logic outBufOvf,
    input wire logic rqsSet,
    output logic rqsBit,
    output logic eventSummary,
    output logic opcQueryDone,
    output logic [7:0] eventStatus,
    output logic [7:0] enableMask
);
    typedef struct packed {
        logic [7:0] esr;
        logic [7:0] mask;
        logic rqs;
        logic opcPend;
        logic opcqPend;
        logic opcqDone;
        logic rspValid;
        logic [7:0] rspData;
    } esr_state_t;

    esr_state_t s_q;
    esr_state_t s_d;
    esr_cmd_t cmd;
    logic [7:0] errLatest;
    logic doCls;
    logic anyPush;
    logic [7:0] pushCode;

    assign cmd = esr_cmd_t'(cmdCode);
    // One command per cycle; every command but OPC and OPCQ completes before the next
    assign cmdReady = 1'b1;
    // Either interface may clear; cmdFromSerial is only informational
    assign doCls = cmdValid && cmd == ESR_CMD_CLS;
    assign anyPush = errPush || outBufOvf;
    assign pushCode = outBufOvf ? ERR_OUTBUF_OVF : errCode;

    esr_err_queue u_errq (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .push(anyPush),
        .pushCode(pushCode),
        .flush(doCls),
        .latest(errLatest),
        // Queue overflow left unconnected; it raises no query-error event
        .overflow()
    );

    function automatic logic [7:0] evt_vec(input logic opc, input logic qye);
        logic [7:0] v;
        v = '0;
        v[BIT_URQ] = evtUserReq;
        v[BIT_CME] = evtCmdErr;
        v[BIT_EXE] = evtExecErr;
        v[BIT_DDE] = evtDevErr;
        v[BIT_QYE] = qye;
        v[BIT_OPC] = opc;
        v[BIT_RQC] = evtReqCtrl;
        return v;
    endfunction : evt_vec

    always_comb begin
        logic opcFire;
        logic [7:0] evts;
        opcFire = 1'b0;
        evts = '0;
        s_d = s_q;
        s_d.rspValid = 1'b0;
        s_d.opcqDone = 1'b0;
        if (cmdValid) begin
            unique case (cmd)
                ESR_CMD_NOP: begin
                end
                ESR_CMD_CLS: begin
                    s_d.esr = '0;
                    s_d.rqs = 1'b0;
                    s_d.opcPend = 1'b0;
                    s_d.opcqPend = 1'b0;
                end
                ESR_CMD_ESE: begin
                    s_d.mask = cmdParam;
                end
                ESR_CMD_ESEQ: begin
                    s_d.rspValid = 1'b1;
                    s_d.rspData = s_q.mask;
                end
                ESR_CMD_ESRQ: begin
                    s_d.rspValid = 1'b1;
                    s_d.rspData = s_q.esr;
                    s_d.esr = '0;
                end
                ESR_CMD_FAULTQ: begin
                    s_d.rspValid = 1'b1;
                    s_d.rspData = errLatest;
                end
                ESR_CMD_OPC: begin
                    s_d.opcPend = 1'b1;
                end
                ESR_CMD_OPCQ: begin
                    s_d.opcqPend = 1'b1;
                end
            endcase
        end
        // Completion only counts for operations still pending
        if (opDone && !doCls) begin
            opcFire = s_q.opcPend;
            s_d.opcqDone = s_q.opcqPend;
            s_d.opcPend = 1'b0;
            s_d.opcqPend = 1'b0;
        end
        // Events set after clears so a same-cycle event is not lost
        evts = evt_vec(opcFire, evtQueryErr || outBufOvf);
        s_d.esr = s_d.esr | evts;
        if (rqsSet) begin
            s_d.rqs = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q.esr <= ESR_RESET;
            s_q.mask <= MASK_RESET;
            s_q.rqs <= 1'b0;
            s_q.opcPend <= 1'b0;
            s_q.opcqPend <= 1'b0;
            s_q.opcqDone <= 1'b0;
            s_q.rspValid <= 1'b0;
            s_q.rspData <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign rspValid = s_q.rspValid;
    assign rspData = s_q.rspData;
    assign rqsBit = s_q.rqs;
    assign opcQueryDone = s_q.opcqDone;
    assign eventStatus = s_q.esr;
    assign enableMask = s_q.mask;
    // Summary bit for the status byte; mask gates only here
    assign eventSummary = |(s_q.esr & s_q.mask);
endmodule : esr_status_regs

/* bench/esr_status_regs_properties.sv */
`timescale 1ns/10ps
module esr_status_regs_checker
    import esr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic [7:0] cmdParam,
    input wire logic rspValid,
    input wire logic [7:0] rspData,
    input wire logic evtUserReq,
    input wire logic evtCmdErr,
    input wire logic evtExecErr,
    input wire logic evtDevErr,
    input wire logic evtQueryErr,
    input wire logic evtReqCtrl,
    input wire logic opDone,
    input wire logic errPush,
    input wire logic outBufOvf,
    input wire logic rqsSet,
    input wire logic rqsBit,
    input wire logic opcQueryDone,
    input wire logic [7:0] eventStatus,
    input wire logic [7:0] enableMask
);
    logic take, quiet, isQ;
    assign take = ce && cmdValid;
    assign isQ = cmdCode inside {3'h3, 3'h4, 3'h5};
    // Same-cycle events win over clears, so clears are judged when quiet
    assign quiet = !(evtUserReq | evtCmdErr | evtExecErr | evtDevErr |
        evtQueryErr | evtReqCtrl | opDone | errPush | outBufOvf);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_ans; take && isQ |=> rspValid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_silent; ce && !(take && isQ) |=> !rspValid; endproperty
    a_silent: assert property (p_silent) else $error("stray answer");
    property p_load;
        take && cmdCode == ESR_CMD_ESE |=> enableMask == $past(cmdParam);
    endproperty
    a_load: assert property (p_load) else $error("mask not loaded");
    property p_maskq;
        take && cmdCode == ESR_CMD_ESEQ |=>
            rspData == $past(enableMask) && $stable(enableMask);
    endproperty
    a_maskq: assert property (p_maskq) else $error("mask query");
    property p_read;
        take && cmdCode == ESR_CMD_ESRQ |=> rspData == $past(eventStatus);
    endproperty
    a_read: assert property (p_read) else $error("event query");
    property p_clr;
        take && quiet && cmdCode inside {3'h1, 3'h4} |=> eventStatus == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("event not cleared");
    property p_rqs;
        take && !rqsSet && cmdCode == ESR_CMD_CLS |=> !rqsBit && !opcQueryDone;
    endproperty
    a_rqs: assert property (p_rqs) else $error("clear status");
    property p_keep;
        take && quiet && cmdCode == ESR_CMD_ESE |=> $stable(eventStatus);
    endproperty
    a_keep: assert property (p_keep) else $error("mask load hit events");
    property p_dde; ce && evtDevErr |=> eventStatus[BIT_DDE]; endproperty
    a_dde: assert property (p_dde) else $error("device error lost");
    property p_ovf; ce && outBufOvf |=> eventStatus[BIT_QYE]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    c_read: cover property (take && cmdCode == ESR_CMD_ESRQ ##1 rspValid);
    c_cls: cover property (take && cmdCode == ESR_CMD_CLS);
    c_ovf: cover property (ce && outBufOvf);
endmodule : esr_status_regs_checker

bind esr_status_regs esr_status_regs_checker chk (.*);

/* bench/esr_host_model.sv */
`timescale 1ns/10ps
module esr_host_model
    import esr_pkg::*;
(
    input wire logic core_clk,
    output logic cmdValid,
    output logic [2:0] cmdCode,
    output logic [7:0] cmdParam,
    output logic cmdFromSerial
);
    initial begin
        cmdValid = 1'b0;
        cmdCode = 3'h0;
        cmdParam = 8'h00;
        cmdFromSerial = 1'b0;
    end
    task automatic send(input esr_cmd_t code, input logic [7:0] prm);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdParam <= prm;
        cmdFromSerial <= 1'($urandom_range(1));
        @(posedge core_clk);
        cmdValid <= 1'b0;
        // Released byte must not look like the last one
        cmdParam <= ~prm;
    endtask : send
endmodule : esr_host_model

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench
    import esr_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [9:0] stim = 10'h000;
    logic [7:0] errCode = 8'h00;
    logic cmdValid, cmdFromSerial, rspValid, rqsBit, opcQueryDone;
    logic eventSummary, cmdReady;
    logic [2:0] cmdCode;
    logic [7:0] cmdParam, rspData, eventStatus, enableMask, got, m;
    int fails = 0, checkCount = 0;
    wire evtUserReq = stim[0], evtCmdErr = stim[1], evtExecErr = stim[2];
    wire evtDevErr = stim[3], evtQueryErr = stim[4], evtReqCtrl = stim[5];
    wire opDone = stim[6], errPush = stim[7], outBufOvf = stim[8];
    wire rqsSet = stim[9];
    `define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin fails++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
    always #2 core_clk = ~core_clk;
    esr_host_model host (.*);
    esr_status_regs dut (.*);
    task automatic ask(input esr_cmd_t c, input logic [7:0] p);
        host.send(c, p);
        #1 got = rspData;
    endtask : ask
    task automatic pulse(input int i, input logic [7:0] code);
        @(posedge core_clk);
        stim <= 10'h001 << i;
        errCode <= code;
        @(posedge core_clk);
        stim <= 10'h000;
    endtask : pulse
    function automatic logic [7:0] bitOf(input int i);
        int pos[6] = '{BIT_URQ, BIT_CME, BIT_EXE, BIT_DDE, BIT_QYE, BIT_RQC};
        return 8'h01 << pos[i];
    endfunction : bitOf
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'hA7857DCC));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1 `CHK(enableMask, 8'h00)
        `CHK(cmdReady, 1'b1)
        ask(ESR_CMD_ESRQ, 8'h00);
        `CHK(got, 8'h01 << BIT_PON)
        ask(ESR_CMD_ESRQ, 8'h00);
        `CHK(got, 8'h00)
        $display("test reset done");
        for (int k = 0; k < 12; k++) begin
            m = k == 0 ? 8'h00 : k == 1 ? 8'hFF : k == 2 ? 8'h8C : 8'($urandom);
            ask(ESR_CMD_ESE, m);
            `CHK(rspValid, 1'b0)
            ask(ESR_CMD_ESEQ, 8'h00);
            `CHK(got, m)
            `CHK(eventStatus, 8'h00)
        end
        $display("test mask done");
        for (int i = 0; i < 6; i++) begin
            pulse(i, 8'h00);
            #1 `CHK(eventSummary, |(bitOf(i) & m))
            ask(ESR_CMD_ESRQ, 8'h00);
            `CHK(got, bitOf(i))
        end
        ask(ESR_CMD_OPC, 8'h00);
        pulse(6, 8'h00);
        ask(ESR_CMD_ESRQ, 8'h00);
        `CHK(got, 8'h01 << BIT_OPC)
        $display("test bits done");
        ask(ESR_CMD_OPCQ, 8'h00);
        pulse(6, 8'h00);
        #1 `CHK(opcQueryDone, 1'b1)
        `CHK(eventStatus, 8'h00)
        m = 8'($urandom_range(120, 1));
        pulse(7, m);
        ask(ESR_CMD_FAULTQ, 8'h00);
        `CHK(got, m)
        pulse(8, 8'h00);
        ask(ESR_CMD_FAULTQ, 8'h00);
        `CHK(got, 8'd122)
        `CHK(eventStatus, 8'h01 << BIT_QYE)
        pulse(9, 8'h00);
        ask(ESR_CMD_OPCQ, 8'h00);
        ask(ESR_CMD_CLS, 8'h00);
        `CHK(rqsBit, 1'b0)
        pulse(6, 8'h00);
        #1 `CHK(opcQueryDone, 1'b0)
        ask(ESR_CMD_FAULTQ, 8'h00);
        `CHK(got, 8'h00)
        ask(ESR_CMD_ESRQ, 8'h00);
        `CHK(got, 8'h00)
        $display("test clear done");
        repeat (150) begin
            stim <= 10'($urandom) & 10'($urandom) & 10'($urandom);
            errCode <= 8'($urandom);
            ce <= ($urandom_range(7) != 0);
            host.send(esr_cmd_t'($urandom_range(7)), 8'($urandom));
        end
        $display("test random done");
        give_verdict;
    end
endmodule : testbench
